/* File: hw/rtc_core.sv */
// Clock core with byte-wide host port, double-buffered time set, alarm, watchdog and power control
// Function
// - Write strobe with chip select takes the data bus byte as write data.
// - Every host access is blocked while the supply is out of tolerance.
// - Date rolls over short months and leap years automatically.
// - An internal counting set and a host-visible set are kept.
// - Copying into the host-visible set can be suspended and resumed.
// - Internal set advances every second while the oscillator runs.
// - Host port deselects itself when the supply falls below trip.
// - Alarm, watchdog or wake event can drive the interrupt; besides power fail, only the watchdog can drive the reset output.
// - Power request asserts on wake event, date alarm, or either.
// - Software can release the power request.
// - Reset output holds during power fail and for the recovery time after supply recovers.
// - Select, write and output enable decode deselect, write and read modes.
// - Data bus driven only while output enable is low.
// - Host accesses honoured only while chip select is low.
// - Five address bits select one of seventeen locations.
// - Gate bit zero stops copying to host set, one resumes it.
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_core
   import rtc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_SEC * `CLK_HZ,
   parameter int unsigned REC_CYCLES  = `REC_TIME_MS * (`CLK_HZ / 1000)
)(
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic       supply_ok_in,
   input  wire logic       osc_run_in,
   input  wire logic       chip_sel_n_in,
   input  wire logic       out_en_n_in,
   input  wire logic       write_en_n_in,
   input  wire logic [4:0] register_select_in,
   input  wire logic [7:0] data_bus_in,
   input  wire logic       wake_event_in_n,
   output logic      [7:0] data_bus_out,
   output logic            data_bus_oe_out,
   output logic            irq_n_out,
   output logic            supply_request_n_out,
   output logic            reset_n_out
);
   typedef struct packed {
      reg_file_t   regs;
      logic [31:0] pre;
      logic [31:0] rec;
      byte_t       wd_cnt;
      byte_t       wd_rst;
      logic        tick;
      logic        tick_d;
      logic        load;
      logic        dirty;
      logic        kick_prev;
      byte_t       dq;
      logic        dq_oe;
      logic        irq_n;
      logic        pwr_n;
      logic        rst_n;
   } core_s;

   core_s                   st_r;
   core_s                   st_nxt;
   logic                    acc;
   logic                    wr;
   logic                    mapped;
   logic [`ALARM_COUNT-1:0] al_hit;
   cal_if                   cal_bus ();

   rtc_calendar u_cal (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .cal        (cal_bus.cal)
   );

   // Counting set is fed from the core's registers
   assign cal_bus.tick     = st_r.tick;
   assign cal_bus.load     = st_r.load;
   assign cal_bus.load_val = st_r.regs[7:0];

   // Port decode: supply in tolerance and chip select low
   assign acc    = supply_ok_in & ~chip_sel_n_in;
   assign wr     = acc & ~write_en_n_in;
   assign mapped = register_select_in <= `REG_SCRATCH;

   // Alarm match per field, bit 7 of an alarm byte means any value
   genvar gi;
   generate
      for (gi = 0; gi < `ALARM_COUNT; gi++) begin : g_alarm
         localparam int CIDX = (gi == 3) ? 4 : gi;
         assign al_hit[gi] = st_r.regs[8 + gi][`ALARM_MASK]
                             | (st_r.regs[8 + gi] == cal_bus.count[CIDX]);
      end
   endgenerate

   // Next state of the whole core
   always_comb begin
      logic te;
      logic al_ev;
      logic wd_ev;
      logic ks_ev;
      te     = st_r.regs[`REG_CTLB][`CTLB_TE];
      al_ev  = st_r.tick_d & (&al_hit);
      wd_ev  = 1'b0;
      ks_ev  = st_r.kick_prev & ~wake_event_in_n;
      st_nxt = st_r;
      st_nxt.tick      = 1'b0;
      st_nxt.load      = 1'b0;
      st_nxt.tick_d    = st_r.tick;
      st_nxt.kick_prev = wake_event_in_n;

      // Seconds prescaler, independent of the host set
      if (osc_run_in) begin
         if (st_r.pre == 32'(TICK_CYCLES - 1)) begin
            st_nxt.pre  = 32'h0000_0000;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.pre = st_r.pre + 32'h0000_0001;
         end
      end

      // Copy counts out while the gate is open, push host edits in on reopen
      if (te && !st_r.dirty && !st_r.load) begin
         st_nxt.regs[7:0] = cal_bus.count;
      end
      if (te && st_r.dirty) begin
         st_nxt.load  = 1'b1;
         st_nxt.dirty = 1'b0;
      end

      // Watchdog counts seconds down from its reload value
      if (st_r.wd_rst != 8'h00) begin
         st_nxt.wd_rst = st_r.wd_rst - 8'h01;
      end
      if (st_r.tick && st_r.regs[`REG_CTLB][`CTLB_WDE] && st_r.wd_cnt != 8'h00) begin
         if (st_r.wd_cnt == 8'h01) begin
            wd_ev         = 1'b1;
            st_nxt.wd_cnt = st_r.regs[`REG_WDOG];
            if (st_r.regs[`REG_CTLB][`CTLB_WDS]) begin
               st_nxt.wd_rst = `WD_RST_CYCLES;
            end
         end else begin
            st_nxt.wd_cnt = st_r.wd_cnt - 8'h01;
         end
      end

      // Host write; flag bits clear on a one
      if (wr && mapped) begin
         case (register_select_in)
            `REG_CTLA: begin
               st_nxt.regs[`REG_CTLA][2:0] = st_r.regs[`REG_CTLA][2:0] & ~data_bus_in[2:0];
               if (data_bus_in[`CTLA_PREL]) begin
                  st_nxt.pwr_n = 1'b1;
               end
            end
            `REG_WDCNT: begin
            end
            `REG_WDOG: begin
               st_nxt.regs[`REG_WDOG] = data_bus_in;
               st_nxt.wd_cnt          = data_bus_in;
            end
            default: begin
               st_nxt.regs[register_select_in] = data_bus_in;
               if (register_select_in <= `REG_CENT) begin
                  st_nxt.dirty = 1'b1;
               end
            end
         endcase
      end
      st_nxt.regs[`REG_WDCNT] = st_nxt.wd_cnt;

      // Events set their flags after any clear, so a set wins
      if (al_ev) begin
         st_nxt.regs[`REG_CTLA][`CTLA_AF] = 1'b1;
      end
      if (wd_ev) begin
         st_nxt.regs[`REG_CTLA][`CTLA_WF] = 1'b1;
      end
      if (ks_ev) begin
         st_nxt.regs[`REG_CTLA][`CTLA_KF] = 1'b1;
      end

      // Power request from wake event or date alarm
      if ((ks_ev && st_r.regs[`REG_CTLB][`CTLB_KSE])
          || (al_ev && st_r.regs[`REG_CTLB][`CTLB_AWE])) begin
         st_nxt.pwr_n = 1'b0;
      end

      // Recovery hold after a power fail
      if (!supply_ok_in) begin
         st_nxt.rec = 32'(REC_CYCLES);
      end else if (st_r.rec != 32'h0000_0000) begin
         st_nxt.rec = st_r.rec - 32'h0000_0001;
      end
      st_nxt.rst_n = supply_ok_in && st_nxt.rec == 32'h0000_0000
                     && st_nxt.wd_rst == 8'h00;

      // Interrupt from enabled flags
      st_nxt.irq_n = !((st_nxt.regs[`REG_CTLA][`CTLA_AF] && st_r.regs[`REG_CTLB][`CTLB_AIE])
                     || (st_nxt.regs[`REG_CTLA][`CTLA_WF] && st_r.regs[`REG_CTLB][`CTLB_WDE]
                         && !st_r.regs[`REG_CTLB][`CTLB_WDS])
                     || (st_nxt.regs[`REG_CTLA][`CTLA_KF]
                         && st_r.regs[`REG_CTLB][`CTLB_KIE]));

      // Read path: drive only with select, write high and output enable low
      st_nxt.dq_oe = acc & write_en_n_in & ~out_en_n_in;
      st_nxt.dq    = mapped ? st_r.regs[register_select_in] : 8'h00;
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r                  <= '0;
         st_r.regs[7:0]        <= {`RST_CENT, `RST_YEAR, `RST_MONTH, `RST_DATE,
                                   `RST_DOW, `RST_HOUR, `RST_MIN, `RST_SEC};
         st_r.regs[`REG_CTLB]  <= `RST_CTLB;
         st_r.rec              <= 32'(REC_CYCLES);
         st_r.kick_prev        <= 1'b1;
         st_r.irq_n            <= 1'b1;
         st_r.pwr_n            <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign data_bus_out         = st_r.dq;
   assign data_bus_oe_out      = st_r.dq_oe;
   assign irq_n_out            = st_r.irq_n;
   assign supply_request_n_out = st_r.pwr_n;
   assign reset_n_out          = st_r.rst_n;

   // Bus released after a supply drop
   property p_fail_hiz;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !supply_ok_in |=> !data_bus_oe_out;
   endproperty
   a_fail_hiz: assert property (p_fail_hiz) else $error("bus driven on low supply");

   // Drive only for a selected read with output enable low
   property p_read_drive;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      data_bus_oe_out |-> $past(supply_ok_in && !chip_sel_n_in && !out_en_n_in && write_en_n_in);
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("bus driven without read");

   // Written byte lands in the scratch location
   property p_write_take;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (wr && register_select_in == `REG_SCRATCH) |=> st_r.regs[`REG_SCRATCH] == $past(data_bus_in);
   endproperty
   a_write_take: assert property (p_write_take) else $error("write byte not taken");

   // Unmapped location reads as zero
   property p_unmapped;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (acc && register_select_in > `REG_SCRATCH) |=> data_bus_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // Reset output low during and after a power fail
   property p_fail_reset;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      !supply_ok_in |=> !reset_n_out [*2];
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("reset released early");

   // Gate closed: host seconds stay put unless the host writes them
   property p_gate_hold;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (!st_r.regs[`REG_CTLB][`CTLB_TE] && !(wr && register_select_in == `REG_SEC))
      |=> st_r.regs[`REG_SEC] == $past(st_r.regs[`REG_SEC]);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("host set changed while gated");

   // Wake event raises the power request
   property p_kick_power;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (st_r.kick_prev && !wake_event_in_n && st_r.regs[`REG_CTLB][`CTLB_KSE])
      |=> !supply_request_n_out;
   endproperty
   a_kick_power: assert property (p_kick_power) else $error("power not requested");

   // Software release lifts the power request when no event is pending
   property p_pwr_release;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (wr && register_select_in == `REG_CTLA && data_bus_in[`CTLA_PREL]
       && !(st_r.kick_prev && !wake_event_in_n) && !st_r.tick_d) |=> supply_request_n_out;
   endproperty
   a_pwr_release: assert property (p_pwr_release) else $error("power not released");

   // Watchdog expiry with steering pulls the reset output low
   property p_wd_steer;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (st_r.tick && st_r.regs[`REG_CTLB][`CTLB_WDE] && st_r.regs[`REG_CTLB][`CTLB_WDS]
       && st_r.wd_cnt == 8'h01) |=> !reset_n_out;
   endproperty
   a_wd_steer: assert property (p_wd_steer) else $error("watchdog reset missing");

   // Wake edge sets its flag even when a clear lands in the same cycle
   property p_kick_flag;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (st_r.kick_prev && !wake_event_in_n) |=> st_r.regs[`REG_CTLA][`CTLA_KF];
   endproperty
   a_kick_flag: assert property (p_kick_flag) else $error("wake flag not set");

   // Deselected port leaves the scratch byte untouched
   property p_desel_hold;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      chip_sel_n_in |=> st_r.regs[`REG_SCRATCH] == $past(st_r.regs[`REG_SCRATCH]);
   endproperty
   a_desel_hold: assert property (p_desel_hold) else $error("write while deselected");
endmodule

/* File: hw/rtc_cfg.svh */
// Register map, field positions, reset values and timing counts of the clock core
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register locations
`define REG_SEC      5'h00
`define REG_MIN      5'h01
`define REG_HOUR     5'h02
`define REG_DOW      5'h03
`define REG_DATE     5'h04
`define REG_MONTH    5'h05
`define REG_YEAR     5'h06
`define REG_CENT     5'h07
`define REG_ASEC     5'h08
`define REG_WDOG     5'h0C
`define REG_WDCNT    5'h0D
`define REG_CTLA     5'h0E
`define REG_CTLB     5'h0F
`define REG_SCRATCH  5'h10
`define ALARM_COUNT  4

// Status and control bits
`define CTLA_AF      0
`define CTLA_WF      1
`define CTLA_KF      2
`define CTLA_PREL    3
`define CTLB_AIE     0
`define CTLB_WDE     1
`define CTLB_KIE     2
`define CTLB_WDS     3
`define CTLB_KSE     4
`define CTLB_AWE     5
`define CTLB_TE      7
`define ALARM_MASK   7

// Reset values
`define RST_SEC      8'h00
`define RST_MIN      8'h00
`define RST_HOUR     8'h00
`define RST_DOW      8'h01
`define RST_DATE     8'h01
`define RST_MONTH    8'h01
`define RST_YEAR     8'h00
`define RST_CENT     8'h20
`define RST_CTLB     8'h80

// Timing
`define CLK_HZ        200000000
`define TICK_SEC      1
`define REC_TIME_MS   150
`define WD_RST_CYCLES 8'h10

`endif

/* File: hw/rtc_pkg.sv */
// Shared types of the clock core
package rtc_pkg;
   typedef logic [7:0]     byte_t;
   typedef byte_t [7:0]    cal_set_t;
   typedef byte_t [16:0]   reg_file_t;
endpackage

/* File: hw/cal_if.sv */
// Link between the host-side core and the internal counting set
`timescale 1ns/100ps
interface cal_if
   import rtc_pkg::*;
();
   logic     tick;
   logic     load;
   cal_set_t load_val;
   cal_set_t count;
   modport core (output tick, output load, output load_val, input count);
   modport cal  (input tick, input load, input load_val, output count);
endinterface

/* File: hw/rtc_calendar.sv */
// Internal BCD counting set of seconds through century
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_calendar
   import rtc_pkg::*;
(
   input  wire logic clk_sys_in,
   input  wire logic arst_n_in,
   cal_if.cal        cal
);
   typedef struct packed {
      cal_set_t cnt;
   } cal_s;

   cal_s st_r;
   cal_s st_nxt;

   // BCD increment of one byte
   function automatic byte_t bcd_inc(input byte_t v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // BCD byte to binary
   function automatic logic [6:0] bcd2bin(input byte_t v);
      bcd2bin = 7'({3'h0, v[7:4]} * 7'h0A + {3'h0, v[3:0]});
   endfunction

   // Last date of the month with leap-year handling
   function automatic byte_t last_day(input byte_t mon, input byte_t yr, input byte_t cen);
      logic leap;
      leap = (bcd2bin(yr) % 7'h04 == 7'h00) && ((yr != 8'h00) || (bcd2bin(cen) % 7'h04 == 7'h00));
      case (mon)
         8'h02:   last_day = leap ? 8'h29 : 8'h28;
         8'h04,
         8'h06,
         8'h09,
         8'h11:   last_day = 8'h30;
         default: last_day = 8'h31;
      endcase
   endfunction

   // Next count: load from the host set, or advance one second with carries
   always_comb begin
      st_nxt = st_r;
      if (cal.load) begin
         st_nxt.cnt = cal.load_val;
      end else if (cal.tick) begin
         st_nxt.cnt[`REG_SEC] = bcd_inc(st_r.cnt[`REG_SEC]);
         if (st_r.cnt[`REG_SEC] == 8'h59) begin
            st_nxt.cnt[`REG_SEC] = 8'h00;
            st_nxt.cnt[`REG_MIN] = bcd_inc(st_r.cnt[`REG_MIN]);
            if (st_r.cnt[`REG_MIN] == 8'h59) begin
               st_nxt.cnt[`REG_MIN]  = 8'h00;
               st_nxt.cnt[`REG_HOUR] = bcd_inc(st_r.cnt[`REG_HOUR]);
               if (st_r.cnt[`REG_HOUR] == 8'h23) begin
                  st_nxt.cnt[`REG_HOUR] = 8'h00;
                  st_nxt.cnt[`REG_DOW]  = (st_r.cnt[`REG_DOW] == 8'h07) ? 8'h01
                                          : bcd_inc(st_r.cnt[`REG_DOW]);
                  st_nxt.cnt[`REG_DATE] = bcd_inc(st_r.cnt[`REG_DATE]);
                  if (st_r.cnt[`REG_DATE] == last_day(st_r.cnt[`REG_MONTH],
                      st_r.cnt[`REG_YEAR], st_r.cnt[`REG_CENT])) begin
                     st_nxt.cnt[`REG_DATE]  = 8'h01;
                     st_nxt.cnt[`REG_MONTH] = bcd_inc(st_r.cnt[`REG_MONTH]);
                     if (st_r.cnt[`REG_MONTH] == 8'h12) begin
                        st_nxt.cnt[`REG_MONTH] = 8'h01;
                        st_nxt.cnt[`REG_YEAR]  = bcd_inc(st_r.cnt[`REG_YEAR]);
                        if (st_r.cnt[`REG_YEAR] == 8'h99) begin
                           st_nxt.cnt[`REG_YEAR] = 8'h00;
                           st_nxt.cnt[`REG_CENT] = bcd_inc(st_r.cnt[`REG_CENT]);
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r.cnt <= {`RST_CENT, `RST_YEAR, `RST_MONTH, `RST_DATE,
                      `RST_DOW, `RST_HOUR, `RST_MIN, `RST_SEC};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cal.count = st_r.cnt;

   // Seconds wrap to zero on a tick
   property p_sec_wrap;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (cal.tick && !cal.load && st_r.cnt[`REG_SEC] == 8'h59) |=> st_r.cnt[`REG_SEC] == 8'h00;
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");

   // February of a leap year runs to the 29th
   property p_leap_day;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (cal.tick && !cal.load && st_r.cnt[2:0] == {8'h23, 8'h59, 8'h59}
       && st_r.cnt[`REG_DATE] == 8'h28 && st_r.cnt[`REG_MONTH] == 8'h02
       && st_r.cnt[`REG_YEAR] == 8'h04) |=> st_r.cnt[`REG_DATE] == 8'h29;
   endproperty
   a_leap_day: assert property (p_leap_day) else $error("leap day skipped");
endmodule

/* File: tb/host_cpu_model.sv */
// Host processor model driving the byte-wide register port of the clock core
`timescale 1ns/100ps
module host_cpu_model (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] data_bus_in,
   input  wire logic       data_bus_oe_in,
   output logic            chip_sel_n_out,
   output logic            out_en_n_out,
   output logic            write_en_n_out,
   output logic      [4:0] register_select_out,
   output logic      [7:0] data_bus_out,
   output logic            wake_event_out_n
);
   // Idle bus at time zero
   initial begin
      chip_sel_n_out = 1'b1;
      out_en_n_out = 1'b1;
      write_en_n_out = 1'b1;
      register_select_out = 5'h00;
      data_bus_out = 8'h00;
      wake_event_out_n = 1'b1;
   end

   // One write; strobes stand over the sampling edge, then the bus is released
   task automatic wr(input logic [4:0] addr, input logic [7:0] val, input logic sel_n);
      @(posedge clk_sys_in);
      chip_sel_n_out      <= sel_n;
      write_en_n_out      <= 1'b0;
      register_select_out <= addr;
      data_bus_out        <= val;
      @(posedge clk_sys_in);
      chip_sel_n_out      <= 1'b1;
      write_en_n_out      <= 1'b1;
      data_bus_out        <= ~val; // Released bus shows no stale byte
   endtask

   // One read; answer taken one edge after the sampling edge
   task automatic rd(input logic [4:0] addr, input logic sel_n, input logic oe_n,
                     output logic [7:0] val, output logic oe);
      @(posedge clk_sys_in);
      chip_sel_n_out      <= sel_n;
      out_en_n_out        <= oe_n;
      register_select_out <= addr;
      repeat (2) @(posedge clk_sys_in);
      #1;
      val = data_bus_in;
      oe  = data_bus_oe_in;
      @(posedge clk_sys_in);
      chip_sel_n_out      <= 1'b1;
      out_en_n_out        <= 1'b1;
   endtask

   // Outside wake event: a short low pulse on the wake line
   task automatic kick();
      @(posedge clk_sys_in);
      wake_event_out_n <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      wake_event_out_n <= 1'b1;
   endtask
endmodule

/* File: tb/test_battery_backed_rtc_bus_port.sv */
// Self-checking testbench of the clock core host port and timekeeping
`timescale 1ns/100ps
module test_battery_backed_rtc_bus_port;
   import rtc_pkg::*;
   localparam int unsigned TICK = 20;
   localparam int unsigned REC  = 8;
   typedef struct packed {
      logic [4:0] addr;
      logic       do_wr;
      logic [7:0] val;
      logic [7:0] exp;
   } row_s;
   logic       clk_sys_in, arst_n_in, supply_ok_in, osc_run_in;
   logic       cs_n, oe_n, we_n, wake_n, bus_oe, irq_n, req_n, rst_n, o;
   logic [4:0] sel;
   logic [7:0] wdata, rdata, a, b;
   int         n_mismatch, check_count, n;
   row_s       rows [12] = '{'{5'h03, 1'b0, 8'h00, 8'h01}, '{5'h04, 1'b0, 8'h00, 8'h01},
      '{5'h05, 1'b0, 8'h00, 8'h01}, '{5'h06, 1'b0, 8'h00, 8'h00},
      '{5'h07, 1'b0, 8'h00, 8'h20}, '{5'h0F, 1'b0, 8'h00, 8'h80},
      '{5'h10, 1'b1, 8'h5A, 8'h5A}, '{5'h08, 1'b1, 8'h30, 8'h30},
      '{5'h0B, 1'b1, 8'h85, 8'h85}, '{5'h11, 1'b1, 8'hFF, 8'h00},
      '{5'h1F, 1'b1, 8'h3C, 8'h00}, '{5'h10, 1'b1, 8'hA5, 8'hA5}};
   // Month, date, year, expected date, expected month after midnight
   logic [7:0] cal_rows [3][5] = '{'{8'h02, 8'h28, 8'h01, 8'h01, 8'h03},
      '{8'h02, 8'h28, 8'h04, 8'h29, 8'h02}, '{8'h04, 8'h30, 8'h05, 8'h01, 8'h05}};

   rtc_core #(.TICK_CYCLES(TICK), .REC_CYCLES(REC)) dut (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .supply_ok_in(supply_ok_in),
      .osc_run_in(osc_run_in), .chip_sel_n_in(cs_n), .out_en_n_in(oe_n),
      .write_en_n_in(we_n), .register_select_in(sel), .data_bus_in(wdata),
      .wake_event_in_n(wake_n), .data_bus_out(rdata), .data_bus_oe_out(bus_oe),
      .irq_n_out(irq_n), .supply_request_n_out(req_n), .reset_n_out(rst_n));

   host_cpu_model host (
      .clk_sys_in(clk_sys_in), .data_bus_in(rdata), .data_bus_oe_in(bus_oe),
      .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .write_en_n_out(we_n),
      .register_select_out(sel), .data_bus_out(wdata), .wake_event_out_n(wake_n));

   // 200 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // Compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Read a register with full strobes and compare the byte
   task automatic rdchk(input logic [4:0] addr, input logic [7:0] exp);
      host.rd(addr, 1'b0, 1'b0, a, o);
      check(o, 1'b1);
      check(a, exp);
   endtask

   // Wait a bounded time for an output to reach a level
   task automatic wait_lvl(input int which, input logic lvl);
      logic s;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk_sys_in);
         #1;
         s = (which == 0) ? irq_n : (which == 1) ? req_n : rst_n;
         if (s === lvl) break;
      end
      check(s, lvl);
   endtask

   // Count edges that reset output stays low
   task automatic count_low();
      n = 0;
      while (rst_n === 1'b0 && n < 50) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
   endtask

   // Hang guard
   initial begin
      #(50000 * 5);
      n_mismatch++;
      give_verdict();
   end

   // Main sequence
   initial begin
      arst_n_in = 1'b0;
      supply_ok_in = 1'b1;
      osc_run_in = 1'b1;
      n_mismatch = 0;
      check_count = 0;
      repeat (20) @(posedge clk_sys_in);
      #1;
      check({rst_n, irq_n, req_n, bus_oe}, 8'h06);
      arst_n_in <= 1'b1;
      count_low();
      check(n == REC, 1'b1);
      // Register table: writes, reset values, unmapped places
      foreach (rows[i]) begin
         if (rows[i].do_wr) host.wr(rows[i].addr, rows[i].val, 1'b0);
         rdchk(rows[i].addr, rows[i].exp);
      end
      // Deselected or output-disabled accesses
      host.rd(5'h10, 1'b1, 1'b0, a, o);
      check(o, 1'b0);
      host.rd(5'h10, 1'b0, 1'b1, a, o);
      check(o, 1'b0);
      host.wr(5'h10, 8'h77, 1'b1);
      rdchk(5'h10, 8'hA5);
      // Copy gate closed freezes the visible seconds
      host.wr(5'h0F, 8'h00, 1'b0);
      host.rd(5'h00, 1'b0, 1'b0, a, o);
      repeat (3 * TICK) @(posedge clk_sys_in);
      host.rd(5'h00, 1'b0, 1'b0, b, o);
      check(b, a);
      host.wr(5'h0F, 8'h80, 1'b0);
      repeat (5) @(posedge clk_sys_in);
      host.rd(5'h00, 1'b0, 1'b0, b, o);
      check(b !== a, 1'b1);
      // Stopped oscillator holds the count
      osc_run_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      host.rd(5'h00, 1'b0, 1'b0, a, o);
      repeat (3 * TICK) @(posedge clk_sys_in);
      host.rd(5'h00, 1'b0, 1'b0, b, o);
      check(b, a);
      osc_run_in <= 1'b1;
      // Midnight rollover at month ends and leap years
      foreach (cal_rows[i]) begin
         host.wr(5'h0F, 8'h00, 1'b0);
         host.wr(5'h00, 8'h59, 1'b0);
         host.wr(5'h01, 8'h59, 1'b0);
         host.wr(5'h02, 8'h23, 1'b0);
         host.wr(5'h04, cal_rows[i][1], 1'b0);
         host.wr(5'h05, cal_rows[i][0], 1'b0);
         host.wr(5'h06, cal_rows[i][2], 1'b0);
         host.wr(5'h0F, 8'h80, 1'b0);
         repeat (TICK + 5) @(posedge clk_sys_in);
         rdchk(5'h04, cal_rows[i][3]);
         rdchk(5'h05, cal_rows[i][4]);
         rdchk(5'h02, 8'h00);
      end
      // Wake event raises power request and interrupt; software releases
      host.wr(5'h0F, 8'h94, 1'b0);
      host.kick();
      wait_lvl(1, 1'b0);
      wait_lvl(0, 1'b0);
      host.wr(5'h0E, 8'h0C, 1'b0);
      wait_lvl(1, 1'b1);
      wait_lvl(0, 1'b1);
      // Every-second alarm raises interrupt and power request
      for (int r = 8; r < 12; r++) host.wr(r[4:0], 8'h80, 1'b0);
      host.wr(5'h0F, 8'hA1, 1'b0);
      wait_lvl(0, 1'b0);
      wait_lvl(1, 1'b0);
      host.wr(5'h0F, 8'h80, 1'b0);
      host.wr(5'h0E, 8'h09, 1'b0);
      wait_lvl(1, 1'b1);
      wait_lvl(0, 1'b1);
      // Watchdog without steering raises the interrupt
      host.wr(5'h0F, 8'h82, 1'b0);
      host.wr(5'h0C, 8'h01, 1'b0);
      wait_lvl(0, 1'b0);
      host.wr(5'h0F, 8'h80, 1'b0);
      host.wr(5'h0E, 8'h02, 1'b0);
      wait_lvl(0, 1'b1);
      // Watchdog steered to reset output
      host.wr(5'h0F, 8'h8A, 1'b0);
      host.wr(5'h0C, 8'h01, 1'b0);
      wait_lvl(2, 1'b0);
      count_low();
      check(n[7:0], 8'h10);
      check(irq_n, 1'b1);
      host.wr(5'h0F, 8'h80, 1'b0);
      host.wr(5'h0E, 8'h02, 1'b0);
      // Supply failure blocks the port and holds reset
      supply_ok_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      host.wr(5'h10, 8'h33, 1'b0);
      host.rd(5'h10, 1'b0, 1'b0, a, o);
      check(o, 1'b0);
      check(rst_n, 1'b0);
      supply_ok_in <= 1'b1;
      count_low();
      check((n >= REC) && (n <= REC + 2), 1'b1);
      rdchk(5'h10, 8'hA5);
      give_verdict();
   end
endmodule
